//--- hdl/afc_pkg.sv
// Package: register map, field layout, reset values and timing for the fan control block
package afc_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG_MODE     = 8'h00;
   localparam logic [7:0] ADDR_STATUS_ONE   = 8'h02;
   localparam logic [7:0] ADDR_CFG_PINS     = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h05;
   localparam logic [7:0] ADDR_DUTY_RAMP    = 8'h23;
   localparam logic [7:0] ADDR_REMOTE_LOOP  = 8'h24;
   localparam logic [7:0] ADDR_LOCAL_LOOP   = 8'h25;
   localparam logic [7:0] ADDR_LOW_DUTY     = 8'h26;
   localparam logic [7:0] ADDR_PASSIVE_TEMP = 8'h27;
   localparam logic [7:0] ADDR_REMOTE_HIGH  = 8'h28;
   localparam logic [7:0] ADDR_LOCAL_HIGH   = 8'h29;
   localparam logic [7:0] ADDR_REMOTE_CRIT  = 8'h2A;
   localparam logic [7:0] ADDR_LOCAL_CRIT   = 8'h2B;
   localparam logic [7:0] ADDR_DUTY_NOW     = 8'h30;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int MODE_MSB        = 6;
   localparam int MODE_LSB        = 5;
   localparam int SPEED_EN_BIT    = 2;
   localparam int SPEED_MODE_BIT  = 1;
   localparam int OVR_EN_BIT      = 0;
   localparam int RAMP_EN_BIT     = 0;
   localparam int RATE_MSB        = 3;
   localparam int RATE_LSB        = 1;
   localparam int STEP_MSB        = 5;
   localparam int STEP_LSB        = 4;
   localparam int THRE_MSB        = 7;
   localparam int THRE_LSB        = 6;
   localparam int LOOP_LOW_MSB    = 7;
   localparam int LOOP_LOW_LSB    = 3;
   localparam int LOOP_SLOPE_MSB  = 2;
   localparam int LOOP_SLOPE_LSB  = 0;
   // Status bit positions (irq enable uses the same layout)
   localparam int ST_REMOTE_HIGH  = 3;
   localparam int ST_LOCAL_HIGH   = 4;
   localparam int ST_REMOTE_FAULT = 5;
   localparam int ST_REMOTE_CRIT  = 6;
   localparam int ST_LOCAL_CRIT   = 7;

   // -----------------------------------------------------------------
   // Modes, reset values and constants
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_REMOTE_ONLY = 2'h2;
   localparam logic [1:0] MODE_MAX_FAST    = 2'h3;
   localparam logic [7:0] RST_CFG_MODE     = 8'h40;
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] RST_LOOP         = 8'h50;
   localparam logic [7:0] RST_LOW_DUTY     = 8'h40;
   localparam logic [7:0] RST_PASSIVE_TEMP = 8'h0A;
   localparam logic [7:0] RST_HIGH_LIMIT   = 8'h50;
   localparam logic [7:0] RST_CRIT_LIMIT   = 8'h64;
   localparam logic [7:0] DUTY_FULL        = 8'hFF;
   localparam logic [7:0] DUTY_ZERO        = 8'h00;
   localparam logic [7:0] DUTY_MIN_RUN     = 8'h12;  // 7 % of 255, rounded up
   localparam logic [7:0] CRIT_HYST        = 8'h05;  // Degrees below limit to re-arm
   localparam int         LOW_TEMP_SHIFT   = 2;      // Low point field is in 4 degree units

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RAMP_BASE_NS   = 62500000;          // 0.0625 s shortest ramp interval
   localparam int RAMP_BASE_CYC  = RAMP_BASE_NS / CLK_PERIOD_NS;
endpackage : afc_pkg

//--- hdl/afc_loop.sv
// Temperature to duty demand calculation for one control loop
`timescale 1ns/10ps
module afc_loop (
   input  wire logic [7:0] i_temp,
   input  wire logic [7:0] i_loop_ctrl,
   input  wire logic [7:0] i_low_duty,
   input  wire logic [7:0] i_passive_temp,
   output logic      [7:0] o_target
);
   import afc_pkg::*;

   logic [7:0]  low_temp;
   logic [7:0]  slope;
   logic [7:0]  rise;
   logic [15:0] prod;
   logic [16:0] sum;

   // Loop parameters decoded from the control byte
   assign low_temp = {1'b0, i_loop_ctrl[LOOP_LOW_MSB:LOOP_LOW_LSB], 2'b00};
   assign slope    = 8'h01 << i_loop_ctrl[LOOP_SLOPE_MSB:LOOP_SLOPE_LSB];
   assign rise     = (i_temp > low_temp) ? 8'(i_temp - low_temp) : 8'h00;
   assign prod     = {8'h00, rise} * {8'h00, slope};
   assign sum      = {9'h000, i_low_duty} + {1'b0, prod};

   // Regions: passive stop, minimum duty, linear, full scale by saturation
   always_comb begin
      if (i_temp <= i_passive_temp) begin
         o_target = DUTY_ZERO;
      end else if (i_temp <= low_temp) begin
         o_target = i_low_duty;
      end else if (sum > {9'h000, DUTY_FULL}) begin
         o_target = DUTY_FULL;
      end else begin
         o_target = sum[7:0];
      end
   end
endmodule : afc_loop

//--- hdl/afc_core.sv
// Auto temperature fan control loop, duty ramp and alert outputs
//
// What this block does
// - Mode 10: duty follows remote temperature only
// - Mode 11: faster of local and remote loops
// - Linear region: slope counts per degree rise
// - At or below low point: low duty
// - At or above high point: full duty
// - At or below passive temp: duty zero
// - Ramp off applies target now, on ramps
// - Ramp interval 0.0625 s to 8 s
// - Each ramp update steps one to four
// - Stop ramping within threshold of target
// - Speed sense on, mode clear: below 7% zero
// - Overtemp pin open-drain, gated by enable bit
// - Critical flag clears on read, re-arms 5 below
// - Overtemp pin low until 5 below limit
// - Sensor fault flag and pin held until reset
// - Sensor fault with enable asserts alert
// - Out-of-limit sets flag, enabled drives alert
// - High flags sticky until condition gone and read
// - Alert held while above a high limit, until read
// - Disabled source still sets its flag
// - Alert is open-drain active-low line
`timescale 1ns/10ps
module afc_core #(
   parameter int P_RAMP_BASE_CYC = afc_pkg::RAMP_BASE_CYC
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_soft_rst,
   input  wire logic [7:0] i_remote_temp,
   input  wire logic [7:0] i_local_temp,
   input  wire logic       i_remote_fault,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   output logic      [7:0] o_pwm_duty,
   output logic            o_overtemp_out_n,
   output logic            o_overtemp_out_n_oe_n,
   output logic            o_smbalert_n,
   output logic            o_smbalert_n_oe_n
);
   import afc_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] cfg_mode_reg;
   logic [7:0] cfg_pins_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] duty_ramp_control_reg;
   logic [7:0] remote_loop_reg;
   logic [7:0] local_loop_reg;
   logic [7:0] low_temp_duty_value_reg;
   logic [7:0] passive_cooling_temp_reg;
   logic [7:0] remote_high_reg;
   logic [7:0] local_high_reg;
   logic [7:0] remote_crit_reg;
   logic [7:0] local_crit_reg;
   logic [7:0] status_one_reg;
   logic [7:0] status_one_next;
   logic       remote_armed_reg;
   logic       local_armed_reg;
   logic       remote_ovr_hold_reg;
   logic       local_ovr_hold_reg;
   logic [7:0] duty_reg;
   logic [7:0] duty_next;
   logic [31:0] base_cnt_reg;
   logic [7:0] ivl_cnt_reg;
   logic       base_tick;
   logic       ramp_tick;
   logic       status_rd;
   logic       any_rst;

   // Field views
   logic [1:0] fan_drive_mode_sel;
   logic       speed_sense_enable;
   logic       speed_sense_mode;
   logic       overtemp_out_enable;
   logic       ramp_enable_bit;
   logic [2:0] ramp_rate_field;
   logic [1:0] ramp_step_field;
   logic [1:0] ramp_threshold_field;
   logic       remote_fault_irq_enable;
   assign fan_drive_mode_sel      = cfg_mode_reg[MODE_MSB:MODE_LSB];
   assign speed_sense_enable      = cfg_mode_reg[SPEED_EN_BIT];
   assign speed_sense_mode        = cfg_mode_reg[SPEED_MODE_BIT];
   assign overtemp_out_enable     = cfg_pins_reg[OVR_EN_BIT];
   assign ramp_enable_bit         = duty_ramp_control_reg[RAMP_EN_BIT];
   assign ramp_rate_field         = duty_ramp_control_reg[RATE_MSB:RATE_LSB];
   assign ramp_step_field         = duty_ramp_control_reg[STEP_MSB:STEP_LSB];
   assign ramp_threshold_field    = duty_ramp_control_reg[THRE_MSB:THRE_LSB];
   assign remote_fault_irq_enable = irq_enable_reg[ST_REMOTE_FAULT];
   // Software reset restores the power-on state of everything but the read data register
   assign any_rst   = i_soft_rst;
   assign status_rd = i_reg_rd && (i_reg_addr == ADDR_STATUS_ONE);

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Plain storage; duty and status are not writable
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_mode_reg             <= RST_CFG_MODE;
         cfg_pins_reg             <= RST_ZERO;
         irq_enable_reg           <= RST_ZERO;
         duty_ramp_control_reg    <= RST_ZERO;
         remote_loop_reg          <= RST_LOOP;
         local_loop_reg           <= RST_LOOP;
         low_temp_duty_value_reg  <= RST_LOW_DUTY;
         passive_cooling_temp_reg <= RST_PASSIVE_TEMP;
         remote_high_reg          <= RST_HIGH_LIMIT;
         local_high_reg           <= RST_HIGH_LIMIT;
         remote_crit_reg          <= RST_CRIT_LIMIT;
         local_crit_reg           <= RST_CRIT_LIMIT;
      end else if (any_rst) begin
         cfg_mode_reg             <= RST_CFG_MODE;
         cfg_pins_reg             <= RST_ZERO;
         irq_enable_reg           <= RST_ZERO;
         duty_ramp_control_reg    <= RST_ZERO;
         remote_loop_reg          <= RST_LOOP;
         local_loop_reg           <= RST_LOOP;
         low_temp_duty_value_reg  <= RST_LOW_DUTY;
         passive_cooling_temp_reg <= RST_PASSIVE_TEMP;
         remote_high_reg          <= RST_HIGH_LIMIT;
         local_high_reg           <= RST_HIGH_LIMIT;
         remote_crit_reg          <= RST_CRIT_LIMIT;
         local_crit_reg           <= RST_CRIT_LIMIT;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            ADDR_CFG_MODE:     cfg_mode_reg             <= i_reg_wdata;
            ADDR_CFG_PINS:     cfg_pins_reg             <= i_reg_wdata;
            ADDR_IRQ_ENABLE:   irq_enable_reg           <= i_reg_wdata;
            ADDR_DUTY_RAMP:    duty_ramp_control_reg    <= i_reg_wdata;
            ADDR_REMOTE_LOOP:  remote_loop_reg          <= i_reg_wdata;
            ADDR_LOCAL_LOOP:   local_loop_reg           <= i_reg_wdata;
            ADDR_LOW_DUTY:     low_temp_duty_value_reg  <= i_reg_wdata;
            ADDR_PASSIVE_TEMP: passive_cooling_temp_reg <= i_reg_wdata;
            ADDR_REMOTE_HIGH:  remote_high_reg          <= i_reg_wdata;
            ADDR_LOCAL_HIGH:   local_high_reg           <= i_reg_wdata;
            ADDR_REMOTE_CRIT:  remote_crit_reg          <= i_reg_wdata;
            ADDR_LOCAL_CRIT:   local_crit_reg           <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Registered read data; unmapped offsets read as zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= RST_ZERO;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            ADDR_CFG_MODE:     o_reg_rdata <= cfg_mode_reg;
            ADDR_STATUS_ONE:   o_reg_rdata <= status_one_reg;
            ADDR_CFG_PINS:     o_reg_rdata <= cfg_pins_reg;
            ADDR_IRQ_ENABLE:   o_reg_rdata <= irq_enable_reg;
            ADDR_DUTY_RAMP:    o_reg_rdata <= duty_ramp_control_reg;
            ADDR_REMOTE_LOOP:  o_reg_rdata <= remote_loop_reg;
            ADDR_LOCAL_LOOP:   o_reg_rdata <= local_loop_reg;
            ADDR_LOW_DUTY:     o_reg_rdata <= low_temp_duty_value_reg;
            ADDR_PASSIVE_TEMP: o_reg_rdata <= passive_cooling_temp_reg;
            ADDR_REMOTE_HIGH:  o_reg_rdata <= remote_high_reg;
            ADDR_LOCAL_HIGH:   o_reg_rdata <= local_high_reg;
            ADDR_REMOTE_CRIT:  o_reg_rdata <= remote_crit_reg;
            ADDR_LOCAL_CRIT:   o_reg_rdata <= local_crit_reg;
            ADDR_DUTY_NOW:     o_reg_rdata <= duty_reg;
            default:           o_reg_rdata <= RST_ZERO;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Duty demand
   // ---------------------------------------------------------------
   logic [7:0] remote_target;
   logic [7:0] local_target;
   logic [7:0] calc_target;
   logic [7:0] target;
   logic       auto_mode;

   afc_loop u_remote_loop (
      .i_temp         (i_remote_temp),
      .i_loop_ctrl    (remote_loop_reg),
      .i_low_duty     (low_temp_duty_value_reg),
      .i_passive_temp (passive_cooling_temp_reg),
      .o_target       (remote_target)
   );
   afc_loop u_local_loop (
      .i_temp         (i_local_temp),
      .i_loop_ctrl    (local_loop_reg),
      .i_low_duty     (low_temp_duty_value_reg),
      .i_passive_temp (passive_cooling_temp_reg),
      .o_target       (local_target)
   );

   // Mode select, then the minimum-run cut for speed sensing
   always_comb begin
      if (fan_drive_mode_sel == MODE_MAX_FAST) begin
         calc_target = (local_target > remote_target) ? local_target : remote_target;
      end else begin
         calc_target = remote_target;
      end
      if (speed_sense_enable && !speed_sense_mode && (calc_target < DUTY_MIN_RUN)) begin
         target = DUTY_ZERO;
      end else begin
         target = calc_target;
      end
   end

   // Software modes are handled elsewhere; duty holds outside auto modes
   assign auto_mode = (fan_drive_mode_sel == MODE_REMOTE_ONLY) || (fan_drive_mode_sel == MODE_MAX_FAST);

   // ---------------------------------------------------------------
   // Ramp timing
   // ---------------------------------------------------------------
   // Base tick every 62.5 ms; interval is 2^rate base ticks
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         base_cnt_reg <= 32'h0000_0000;
      end else if (any_rst || base_tick) begin
         base_cnt_reg <= 32'h0000_0000;
      end else begin
         base_cnt_reg <= base_cnt_reg + 32'h0000_0001;
      end
   end
   assign base_tick = (base_cnt_reg == 32'(P_RAMP_BASE_CYC - 1));

   // Interval counter; ramp_tick ends each programmed interval
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ivl_cnt_reg <= 8'h00;
      end else if (any_rst || ramp_tick) begin
         ivl_cnt_reg <= 8'h00;
      end else if (base_tick) begin
         ivl_cnt_reg <= ivl_cnt_reg + 8'h01;
      end
   end
   assign ramp_tick = base_tick && (ivl_cnt_reg == 8'((8'h01 << ramp_rate_field) - 8'h01));

   // ---------------------------------------------------------------
   // Duty update
   // ---------------------------------------------------------------
   logic [7:0] gap;
   logic [7:0] step;
   assign gap  = (duty_reg > target) ? 8'(duty_reg - target) : 8'(target - duty_reg);
   assign step = {6'h00, ramp_step_field} + 8'h01;

   // Clamp each step so the duty never overshoots the target
   always_comb begin
      duty_next = duty_reg;
      if (auto_mode && !ramp_enable_bit) begin
         duty_next = target;
      end else if (auto_mode && ramp_tick && (gap > {6'h00, ramp_threshold_field})) begin
         if (gap <= step) begin
            duty_next = target;
         end else if (duty_reg < target) begin
            duty_next = 8'(duty_reg + step);
         end else begin
            duty_next = 8'(duty_reg - step);
         end
      end
   end

   // Duty drives the PWM generator directly from this flop
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         duty_reg <= DUTY_ZERO;
      end else begin
         duty_reg <= any_rst ? DUTY_ZERO : duty_next;
      end
   end

   assign o_pwm_duty = duty_reg;

   // ---------------------------------------------------------------
   // Critical limits and hysteresis
   // ---------------------------------------------------------------
   logic [7:0] remote_rearm;
   logic [7:0] local_rearm;
   logic       remote_crit_hit;
   logic       local_crit_hit;
   logic       remote_cooled;
   logic       local_cooled;
   // Saturate so a tiny limit cannot wrap the re-arm point
   assign remote_rearm    = (remote_crit_reg > CRIT_HYST) ? 8'(remote_crit_reg - CRIT_HYST) : 8'h00;
   assign local_rearm     = (local_crit_reg > CRIT_HYST) ? 8'(local_crit_reg - CRIT_HYST) : 8'h00;
   assign remote_crit_hit = (i_remote_temp >= remote_crit_reg);
   assign local_crit_hit  = (i_local_temp >= local_crit_reg);
   assign remote_cooled   = (i_remote_temp <= remote_rearm);
   assign local_cooled    = (i_local_temp <= local_rearm);

   // Pin hold and flag arming both release only 5 degrees below the limit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         remote_ovr_hold_reg <= 1'b0;
         local_ovr_hold_reg  <= 1'b0;
         remote_armed_reg    <= 1'b1;
         local_armed_reg     <= 1'b1;
      end else begin
         remote_ovr_hold_reg <= !any_rst && (remote_crit_hit || (remote_ovr_hold_reg && !remote_cooled));
         local_ovr_hold_reg  <= !any_rst && (local_crit_hit || (local_ovr_hold_reg && !local_cooled));
         remote_armed_reg    <= any_rst || remote_cooled || (remote_armed_reg && !remote_crit_hit);
         local_armed_reg     <= any_rst || local_cooled || (local_armed_reg && !local_crit_hit);
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // A set in the same cycle as the clearing read wins
   always_comb begin
      status_one_next = status_one_reg;
      status_one_next[ST_REMOTE_HIGH] = (i_remote_temp > remote_high_reg)
                                      || (status_one_reg[ST_REMOTE_HIGH] && !status_rd);
      status_one_next[ST_LOCAL_HIGH]  = (i_local_temp > local_high_reg)
                                      || (status_one_reg[ST_LOCAL_HIGH] && !status_rd);
      status_one_next[ST_REMOTE_CRIT] = (remote_crit_hit && remote_armed_reg)
                                      || (status_one_reg[ST_REMOTE_CRIT] && !status_rd);
      status_one_next[ST_LOCAL_CRIT]  = (local_crit_hit && local_armed_reg)
                                      || (status_one_reg[ST_LOCAL_CRIT] && !status_rd);
      status_one_next[ST_REMOTE_FAULT] = i_remote_fault || status_one_reg[ST_REMOTE_FAULT];
   end
   // Flags set regardless of their enable bits; only reset clears the fault
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         status_one_reg <= RST_ZERO;
      end else begin
         status_one_reg <= any_rst ? RST_ZERO : status_one_next;
      end
   end

   // ---------------------------------------------------------------
   // Open-drain outputs
   // ---------------------------------------------------------------
   // Data pins only ever drive low; enables are active low
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_overtemp_out_n      <= 1'b0;
         o_overtemp_out_n_oe_n <= 1'b1;
         o_smbalert_n          <= 1'b0;
         o_smbalert_n_oe_n     <= 1'b1;
      end else begin
         o_overtemp_out_n_oe_n <= any_rst || !(overtemp_out_enable
                                 && (remote_ovr_hold_reg || local_ovr_hold_reg
                                     || status_one_reg[ST_REMOTE_FAULT]));
         o_smbalert_n_oe_n     <= any_rst || !(|(status_one_reg & irq_enable_reg)
                                    || (status_one_reg[ST_REMOTE_FAULT]
                                        && remote_fault_irq_enable));
      end
   end
endmodule : afc_core

//--- tb/afc_core_monitor.sv
// Checker: port-level timing assertions for the fan control core
`timescale 1ns/10ps
module afc_core_monitor import afc_pkg::*; #(parameter int P_RAMP_BASE_CYC = 4) (
   input wire logic       i_clk, i_rst, i_soft_rst, i_remote_fault, i_reg_wr, i_reg_rd,
   input wire logic [7:0] i_reg_addr, i_reg_wdata, i_remote_temp, i_local_temp, o_pwm_duty,
   input wire logic       o_overtemp_out_n, o_overtemp_out_n_oe_n, o_smbalert_n, o_smbalert_n_oe_n
);
   localparam logic [7:0] LIM = RST_CRIT_LIMIT - CRIT_HYST;
   logic ovr_en, fie, sse, flt, flt2;
   wire  cause = i_soft_rst || i_reg_wr || (i_reg_rd && i_reg_addr == ADDR_STATUS_ONE);
   // Shadow enables from writes; fault latch delayed to match the pin flop
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst || i_soft_rst) {ovr_en, fie, sse, flt, flt2} <= '0;
      else begin
         if (i_reg_wr && i_reg_addr == ADDR_CFG_PINS) ovr_en <= i_reg_wdata[OVR_EN_BIT];
         if (i_reg_wr && i_reg_addr == ADDR_IRQ_ENABLE) fie <= i_reg_wdata[ST_REMOTE_FAULT];
         if (i_reg_wr && i_reg_addr == ADDR_CFG_MODE) sse <= i_reg_wdata[SPEED_EN_BIT] & ~i_reg_wdata[SPEED_MODE_BIT];
         flt  <= flt | i_remote_fault;
         flt2 <= flt;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_od_data; !o_overtemp_out_n && !o_smbalert_n; endproperty
   a_od_data: assert property (p_od_data) else $error("open-drain data not low");
   property p_ovr_off; !ovr_en ##1 !ovr_en |-> o_overtemp_out_n_oe_n; endproperty
   a_ovr_off: assert property (p_ovr_off) else $error("overtemp pin driven while disabled");
   property p_ovr_flt; flt2 && ovr_en && $past(ovr_en) |-> !o_overtemp_out_n_oe_n; endproperty
   a_ovr_flt: assert property (p_ovr_flt) else $error("overtemp pin released after fault");
   property p_alert_flt; flt2 && fie && $past(fie) |-> !o_smbalert_n_oe_n; endproperty
   a_alert_flt: assert property (p_alert_flt) else $error("fault alert missing");
   property p_alert_hold; $rose(o_smbalert_n_oe_n) |-> $past(cause) || $past(cause, 2); endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert released without read");
   property p_ovr_hold; $rose(o_overtemp_out_n_oe_n) |-> $past(cause) || $past(cause, 2)
      || ($past(i_remote_temp, 2) <= LIM && $past(i_local_temp, 2) <= LIM); endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("overtemp released above hysteresis");
   property p_min_run; sse [*2] |-> o_pwm_duty == DUTY_ZERO || o_pwm_duty >= DUTY_MIN_RUN; endproperty
   a_min_run: assert property (p_min_run) else $error("duty below minimum run");
   property p_soft; i_soft_rst |=> o_pwm_duty == DUTY_ZERO && o_overtemp_out_n_oe_n && o_smbalert_n_oe_n; endproperty
   a_soft: assert property (p_soft) else $error("soft reset left outputs active");
   c_fault: cover property (flt2 && !o_overtemp_out_n_oe_n);
   c_alert: cover property ($fell(o_smbalert_n_oe_n));
   c_full: cover property (o_pwm_duty == DUTY_FULL);
endmodule : afc_core_monitor
bind afc_core afc_core_monitor #(.P_RAMP_BASE_CYC(P_RAMP_BASE_CYC)) u_mon (.*);

//--- tb/afc_fan_model.sv
// Far side: board pull-ups resolving the two open-drain lines
`timescale 1ns/10ps
module afc_fan_model (
   input  wire logic i_ovr_d, i_ovr_oe_n, i_alert_d, i_alert_oe_n,
   output logic      o_ovr_line, o_alert_line
);
   // A released line floats up to its pull-up, never holds the last value
   assign o_ovr_line   = i_ovr_oe_n ? 1'b1 : i_ovr_d;
   assign o_alert_line = i_alert_oe_n ? 1'b1 : i_alert_d;
endmodule : afc_fan_model

//--- tb/afc_core_tb_top.sv
// Testbench: auto loop, ramp, flag and pin scenarios with a read scoreboard
`timescale 1ns/10ps
module afc_core_tb_top;
   import afc_pkg::*;
   localparam int RB = 4;
   logic       i_clk = 0, i_rst = 1, i_soft_rst = 0, i_remote_fault = 0, i_reg_wr = 0, i_reg_rd = 0;
   logic [7:0] i_remote_temp = 8'h1E, i_local_temp = 8'h1E, i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
   logic [7:0] o_reg_rdata, o_pwm_duty, exp_q[$];
   logic       o_overtemp_out_n, o_overtemp_out_n_oe_n, o_smbalert_n, o_smbalert_n_oe_n, ovr_l, alr_l;
   int         n_fail = 0, num_checks = 0;
   logic [15:0] rv [6] = '{{ADDR_CFG_MODE, RST_CFG_MODE}, {ADDR_DUTY_RAMP, RST_ZERO}, {ADDR_LOW_DUTY, RST_LOW_DUTY},
                          {ADDR_REMOTE_CRIT, RST_CRIT_LIMIT}, {ADDR_STATUS_ONE, RST_ZERO}, {8'h01, RST_ZERO}};
   always #5 i_clk = ~i_clk;
   afc_core #(.P_RAMP_BASE_CYC(RB)) DUT (.*);
   afc_fan_model u_fan (.i_ovr_d(o_overtemp_out_n), .i_ovr_oe_n(o_overtemp_out_n_oe_n), .i_alert_d(o_smbalert_n),
                        .i_alert_oe_n(o_smbalert_n_oe_n), .o_ovr_line(ovr_l), .o_alert_line(alr_l));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic print_verdict;
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // One access per strobe; a read notes its expected byte
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {wr, !wr, a, d};
      if (!wr) exp_q.push_back(d);
      @(negedge i_clk);
      {i_reg_wr, i_reg_rd} = 2'b00;
   endtask : acc
   task automatic duty_case(input logic [7:0] cfg, low, rt, lt, dy);
      acc(1, ADDR_CFG_MODE, cfg);
      acc(1, ADDR_LOW_DUTY, low);
      {i_remote_temp, i_local_temp} = {rt, lt};
      repeat (3) @(negedge i_clk);
      acc(0, ADDR_DUTY_NOW, dy);
   endtask : duty_case
   // Read data is settled by the falling edge after the taking edge
   always @(posedge i_clk) if (i_reg_rd === 1'b1) begin
      @(negedge i_clk);
      check(o_reg_rdata, exp_q.pop_front());
   end
   task automatic pins(input logic [7:0] want);
      repeat (3) @(negedge i_clk);
      check(8'({ovr_l, alr_l}), want);
   endtask : pins
   initial begin
      int w;
      logic [7:0] e;
      void'($urandom(32'hA48BFA54));
      repeat (8) @(negedge i_clk);
      i_rst = 0;
      foreach (rv[i]) acc(0, rv[i][15:8], rv[i][7:0]);
      acc(1, ADDR_LOCAL_LOOP, 8'h53);
      duty_case(8'h40, 8'h40, 8'h1E, 8'h1E, 8'h40);
      duty_case(8'h40, 8'h40, 8'h28, 8'h1E, 8'h40);
      duty_case(8'h60, 8'h40, 8'h1E, 8'h40, 8'hFF);
      duty_case(8'h40, 8'h40, 8'h0A, 8'h1E, 8'h00);
      duty_case(8'h60, 8'h40, 8'h2D, 8'h2D, 8'h68);
      duty_case(8'h60, 8'h40, 8'h2D, 8'h1E, 8'h45);
      duty_case(8'h44, 8'h05, 8'h1E, 8'h1E, 8'h00);
      duty_case(8'h46, 8'h05, 8'h1E, 8'h1E, 8'h05);
      repeat (8) begin
         e = 8'h29 + 8'($urandom % 39);
         duty_case(8'h40, 8'h40, e, 8'h1E, e + 8'h18);
      end
      duty_case(8'h40, 8'h40, 8'h1E, 8'h1E, 8'h40);
      for (int r = 0; r < 2; r++) begin
         acc(1, ADDR_DUTY_RAMP, 8'h11 | 8'(r * 8'h82));
         i_remote_temp = r ? 8'h1E : 8'h32;
         for (w = 0; w < 99 && o_pwm_duty === (r ? 8'h4A : 8'h40); w++) @(negedge i_clk);
         if (w == 99) begin
            n_fail++;
            print_verdict();
         end
         for (int k = 0; k < 6; k++) begin
            e = r ? ((k > 3) ? 8'h42 : 8'h48 - 8'(2 * k)) : ((k > 4) ? 8'h4A : 8'h42 + 8'(2 * k));
            acc(0, ADDR_DUTY_NOW, e);
            repeat ((RB << r) - 2) @(negedge i_clk);
         end
      end
      acc(1, ADDR_DUTY_RAMP, 8'h00);
      duty_case(8'h40, 8'h40, 8'h32, 8'h1E, 8'h4A);
      acc(1, ADDR_CFG_PINS, 8'h01);
      acc(1, ADDR_IRQ_ENABLE, 8'h40);
      i_remote_temp = 8'h64;
      pins(8'h00);
      acc(0, ADDR_STATUS_ONE, 8'h48);
      acc(0, ADDR_STATUS_ONE, 8'h08);
      pins(8'h01);
      i_remote_temp = 8'h60;
      pins(8'h01);
      i_remote_temp = 8'h5F;
      pins(8'h03);
      acc(1, ADDR_IRQ_ENABLE, 8'h00);
      i_remote_temp = 8'h64;
      pins(8'h01);
      acc(0, ADDR_STATUS_ONE, 8'h48);
      i_remote_temp = 8'h1E;
      pins(8'h03);
      acc(0, ADDR_STATUS_ONE, 8'h08);
      acc(0, ADDR_STATUS_ONE, 8'h00);
      acc(1, ADDR_IRQ_ENABLE, 8'h20);
      i_remote_fault = 1;
      @(negedge i_clk);
      i_remote_fault = 0;
      pins(8'h00);
      acc(0, ADDR_STATUS_ONE, 8'h20);
      acc(0, ADDR_STATUS_ONE, 8'h20);
      i_soft_rst = 1;
      @(negedge i_clk);
      i_soft_rst = 0;
      pins(8'h03);
      acc(0, ADDR_STATUS_ONE, 8'h00);
      print_verdict();
   end
endmodule : afc_core_tb_top
